// [rtl/cfg_fifo.sv]
// Purpose: small first-in first-out buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from pointers with one extra wrap bit
`timescale 1ns/1ns
module cfg_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   // fill side
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   // drain side
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         push;
   logic         pop;

   assign o_in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign o_out_valid = (wr_q != rd_q);
   assign o_out_data  = mem_q[rd_q[AW-1:0]];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_q <= '0;
      end else if (push) begin
         wr_q <= wr_q + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rd_q <= '0;
      end else if (pop) begin
         rd_q <= rd_q + 1'b1;
      end
   end

endmodule

// [rtl/cfg_mode_sequencer.sv]
// Purpose: moves the device between command mode (wait, load, init, fail) and user mode
// Assumes: all inputs synchronous to i_clk; the sink takes bytes on valid and ready
// Notes:   bits are packed msb first into bytes that pass through an 8-word buffer
`timescale 1ns/1ns
`include "cfg_seq_map.svh"

module cfg_mode_sequencer
   import cfg_seq_pkg::*;
#(
   parameter int LOAD_TIMEOUT_CYC = `CFG_LOAD_MAX_MS * `CFG_CLK_PER_MS,
   parameter int LOAD_BYTES       = `CFG_LOAD_BYTES
) (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_srst,
   // mode control
   input  wire logic                   i_reload_request_n,
   input  wire logic                   i_chain_enable_in_n,
   input  wire logic [1:0]             i_scheme,
   // jtag port
   input  wire logic [3:0]             i_jtag_position,
   input  wire logic                   i_jtag_instr_valid,
   input  wire logic [9:0]             i_jtag_instr,
   input  wire logic                   i_jtag_bit_valid,
   input  wire logic                   i_jtag_bit,
   // passive serial source
   input  wire logic                   i_ps_bit_valid,
   input  wire logic                   i_ps_bit,
   output logic                        o_serial_ready,
   // active serial memory
   output logic                        o_as_sclk,
   output logic                        o_as_cs_n,
   input  wire logic                   i_as_data,
   // configuration store
   output logic                        o_cfg_wr_valid,
   output logic [`CFG_BYTE_W-1:0]      o_cfg_wr_data,
   input  wire logic                   i_cfg_wr_ready,
   // status and user side
   output logic                        o_load_status_n,
   output logic                        o_chain_enable_out_n,
   output logic                        o_command_mode,
   output logic                        o_user_mode,
   output logic                        o_user_reset,
   output logic                        o_io_pullup_en,
   output logic                        o_io_drive_en
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic pos_ok(input logic [3:0] pos);
      pos_ok = (pos >= `CFG_JTAG_MIN_POS) && (pos <= `CFG_JTAG_MAX_POS);
   endfunction

   function automatic logic scheme_ok(input logic [1:0] sch);
      scheme_ok = (sch == SCH_ACTIVE) || (sch == SCH_PASSIVE) || (sch == SCH_JTAG);
   endfunction

   cfg_state_t              state_q;
   logic                    reload_req;
   logic                    io_stop;
   logic                    tmo_hit;
   logic                    load_done;
   logic [23:0]             tmo_q;
   logic [7:0]              init_q;
   logic [15:0]             pushed_q;
   logic [15:0]             popped_q;
   logic [`CFG_BYTE_W-1:0]  shift_q;
   logic [2:0]              bit_cnt_q;
   logic                    byte_full_q;
   logic                    as_sclk_q;
   logic                    as_cs_n_q;
   logic                    in_load;
   logic                    as_sel;
   logic                    bit_valid;
   logic                    bit_val;
   logic                    bit_take;
   logic                    fifo_in_ready;
   logic                    fifo_pop;

   // -----------------------------------------------------------------
   // mode requests
   // -----------------------------------------------------------------
   assign reload_req = !i_reload_request_n ||
                       (i_jtag_instr_valid && (i_jtag_instr == `CFG_INSTR_RELOAD));
   assign io_stop    = (state_q == ST_LOAD) && i_jtag_instr_valid &&
                       (i_jtag_instr == `CFG_INSTR_IO_CFG);
   assign tmo_hit    = (tmo_q == 24'(LOAD_TIMEOUT_CYC - 1));
   assign load_done  = (popped_q == 16'(LOAD_BYTES));

   // -----------------------------------------------------------------
   // mode state machine
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_q <= ST_WAIT;
      end else if (reload_req) begin
         state_q <= ST_WAIT;
      end else begin
         case (state_q)
            ST_WAIT: begin
               if (!i_chain_enable_in_n) begin
                  if (!scheme_ok(i_scheme)) begin
                     state_q <= ST_FAIL;
                  end else if ((i_scheme == SCH_JTAG) && !pos_ok(i_jtag_position)) begin
                     state_q <= ST_FAIL;
                  end else begin
                     state_q <= ST_LOAD;
                  end
               end
            end
            ST_LOAD: begin
               if (io_stop || tmo_hit) begin
                  state_q <= ST_FAIL;
               end else if (load_done) begin
                  state_q <= ST_INIT;
               end
            end
            ST_INIT: begin
               if (init_q == (`CFG_INIT_TOTAL_CYC - 8'h01)) begin
                  state_q <= ST_USER;
               end
            end
            ST_USER: state_q <= ST_USER;
            default: state_q <= ST_FAIL;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || (state_q != ST_LOAD)) begin
         tmo_q <= 24'h000000;
      end else begin
         tmo_q <= tmo_q + 24'h000001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || (state_q != ST_INIT)) begin
         init_q <= 8'h00;
      end else begin
         init_q <= init_q + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // serial bit intake
   // -----------------------------------------------------------------
   assign in_load        = (state_q == ST_LOAD);
   assign as_sel         = in_load && (i_scheme == SCH_ACTIVE);
   assign o_serial_ready = in_load && !byte_full_q && (pushed_q != 16'(LOAD_BYTES));

   always_comb begin
      bit_valid = 1'b0;
      bit_val   = 1'b0;
      case (i_scheme)
         SCH_ACTIVE: begin
            bit_valid = !as_sclk_q && !as_cs_n_q;
            bit_val   = i_as_data;
         end
         SCH_PASSIVE: begin
            bit_valid = i_ps_bit_valid;
            bit_val   = i_ps_bit;
         end
         SCH_JTAG: begin
            bit_valid = i_jtag_bit_valid;
            bit_val   = i_jtag_bit;
         end
         default: begin
            bit_valid = 1'b0;
            bit_val   = 1'b0;
         end
      endcase
   end

   assign bit_take = o_serial_ready && bit_valid;

   // device drives the memory clock, one edge per cycle while it can take a bit;
   // no rise before the memory is selected, else the first bit is not yet valid
   always_ff @(posedge i_clk) begin
      if (i_srst || !as_sel) begin
         as_sclk_q <= 1'b0;
      end else if ((o_serial_ready && !as_cs_n_q) || as_sclk_q) begin
         as_sclk_q <= !as_sclk_q;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         as_cs_n_q <= 1'b1;
      end else begin
         as_cs_n_q <= !(as_sel && !reload_req && !io_stop && !tmo_hit && !load_done);
      end
   end

   assign o_as_sclk = as_sclk_q;
   assign o_as_cs_n = as_cs_n_q;

   always_ff @(posedge i_clk) begin
      if (bit_take) begin
         shift_q <= {shift_q[`CFG_BYTE_W-2:0], bit_val};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || !in_load) begin
         bit_cnt_q <= 3'h0;
      end else if (bit_take) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || !in_load) begin
         byte_full_q <= 1'b0;
      end else if (bit_take && (bit_cnt_q == `CFG_BYTE_LAST_BIT)) begin
         byte_full_q <= 1'b1;
      end else if (fifo_in_ready) begin
         byte_full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || (state_q == ST_WAIT)) begin
         pushed_q <= 16'h0000;
      end else if (byte_full_q && fifo_in_ready) begin
         pushed_q <= pushed_q + 16'h0001;
      end
   end

   // -----------------------------------------------------------------
   // byte buffer towards the configuration store
   // -----------------------------------------------------------------
   cfg_fifo #(
      .W     (`CFG_BYTE_W),
      .DEPTH (`CFG_FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_srst      (i_srst || (state_q == ST_WAIT)),
      .i_in_valid  (byte_full_q),
      .i_in_data   (shift_q),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (o_cfg_wr_valid),
      .o_out_data  (o_cfg_wr_data),
      .i_out_ready (i_cfg_wr_ready)
   );

   assign fifo_pop = o_cfg_wr_valid && i_cfg_wr_ready;

   always_ff @(posedge i_clk) begin
      if (i_srst || (state_q == ST_WAIT)) begin
         popped_q <= 16'h0000;
      end else if (fifo_pop) begin
         popped_q <= popped_q + 16'h0001;
      end
   end

   // -----------------------------------------------------------------
   // status and pin control
   // -----------------------------------------------------------------
   assign o_load_status_n      = (state_q != ST_FAIL);
   assign o_chain_enable_out_n = !((state_q == ST_INIT) || (state_q == ST_USER));
   assign o_user_mode          = (state_q == ST_USER);
   assign o_command_mode       = !o_user_mode;
   assign o_user_reset         = (state_q != ST_USER) &&
                                 !((state_q == ST_INIT) && (init_q >= `CFG_INIT_RST_CYC));
   assign o_io_drive_en        = o_user_mode ||
                                 ((state_q == ST_INIT) && (init_q >= `CFG_INIT_RST_CYC));
   assign o_io_pullup_en       = !o_io_drive_en;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence load_finishing;
      (state_q == ST_LOAD) && load_done && !reload_req && !io_stop && !tmo_hit;
   endsequence

   sequence init_entered;
      (state_q == ST_INIT) && o_user_reset && !o_io_drive_en;
   endsequence

   chk_jtag_position: assert property (@(posedge i_clk) disable iff (i_srst)
      (state_q == ST_WAIT) && !i_chain_enable_in_n && !reload_req &&
      (i_scheme == SCH_JTAG) && !pos_ok(i_jtag_position) |=> !o_load_status_n)
      else $error("jtag load accepted beyond allowed chain position");

   chk_reset_wait: assert property (@(posedge i_clk)
      i_srst |=> (state_q == ST_WAIT) && o_command_mode && o_io_pullup_en)
      else $error("reset did not return to waiting for a load");

   chk_init_after_load: assert property (@(posedge i_clk) disable iff (i_srst)
      load_finishing |=> init_entered)
      else $error("load end not followed by initialization");

   chk_mode_split: assert property (@(posedge i_clk) disable iff (i_srst)
      o_user_mode |-> !o_user_reset && o_io_drive_en && !o_chain_enable_out_n)
      else $error("user mode entered with command mode outputs");

   chk_reload_pin: assert property (@(posedge i_clk) disable iff (i_srst)
      !i_reload_request_n |=> (state_q == ST_WAIT) && o_command_mode && o_load_status_n)
      else $error("reload pin did not restart the load");

   chk_pullup_load: assert property (@(posedge i_clk) disable iff (i_srst)
      ((state_q == ST_WAIT) || (state_q == ST_LOAD)) |-> o_io_pullup_en && !o_io_drive_en)
      else $error("user pins driven before or during load");

   chk_as_select: assert property (@(posedge i_clk) disable iff (i_srst)
      !o_as_cs_n || o_as_sclk |-> (i_scheme == SCH_ACTIVE) || $past(i_scheme == SCH_ACTIVE))
      else $error("serial memory clocked outside active serial scheme");

   chk_chain_pass: assert property (@(posedge i_clk) disable iff (i_srst)
      load_finishing |=> $fell(o_chain_enable_out_n))
      else $error("chain enable not passed on at end of load");

   chk_load_timeout: assert property (@(posedge i_clk) disable iff (i_srst)
      (state_q == ST_LOAD) && tmo_hit && !reload_req |=> !o_load_status_n)
      else $error("overlong load not aborted");

   chk_pulse_instr: assert property (@(posedge i_clk) disable iff (i_srst)
      i_jtag_instr_valid && (i_jtag_instr == `CFG_INSTR_RELOAD) |=> (state_q == ST_WAIT))
      else $error("reload instruction did not restart the load");

   chk_io_stop_hold: assert property (@(posedge i_clk) disable iff (i_srst)
      io_stop && !reload_req ##1 !reload_req |=> !o_load_status_n)
      else $error("status released after io instruction without reload");

   chk_init_length: assert property (@(posedge i_clk) disable iff (i_srst)
      (state_q == ST_INIT) && (init_q == 8'h00) |-> !o_user_mode [*8])
      else $error("user mode entered before initialization finished");

endmodule

// [rtl/cfg_seq_map.svh]
// Purpose: named offsets, codes and timing figures of the mode sequencer
// Assumes: included by its bare name wherever the figures are needed
// Notes:   definitions only
`ifndef CFG_SEQ_MAP_SVH
`define CFG_SEQ_MAP_SVH

// -----------------------------------------------------------------
// clock and timing
// -----------------------------------------------------------------
`define CFG_CLK_HZ          10000000
`define CFG_CLK_PER_MS      (`CFG_CLK_HZ / 1000)
`define CFG_LOAD_MAX_MS     120
`define CFG_INIT_RST_CYC    8'h08
`define CFG_INIT_TOTAL_CYC  8'h10

// -----------------------------------------------------------------
// chain and instruction codes
// -----------------------------------------------------------------
`define CFG_JTAG_MIN_POS    4'h1
`define CFG_JTAG_MAX_POS    4'h8
`define CFG_INSTR_RELOAD    10'h001
`define CFG_INSTR_IO_CFG    10'h00D

// -----------------------------------------------------------------
// data path
// -----------------------------------------------------------------
`define CFG_BYTE_W          8
`define CFG_BYTE_LAST_BIT   3'h7
`define CFG_FIFO_DEPTH      8
`define CFG_LOAD_BYTES      1024

`endif

// [rtl/cfg_seq_pkg.sv]
// Purpose: types shared by the mode sequencer
// Assumes: nothing
// Notes:   one-hot state codes
package cfg_seq_pkg;

   typedef enum logic [4:0] {
      ST_WAIT = 5'h01,
      ST_LOAD = 5'h02,
      ST_INIT = 5'h04,
      ST_USER = 5'h08,
      ST_FAIL = 5'h10
   } cfg_state_t;

   typedef enum logic [1:0] {
      SCH_ACTIVE  = 2'h0,
      SCH_PASSIVE = 2'h1,
      SCH_JTAG    = 2'h2
   } cfg_scheme_t;

endpackage

// [sim/cfg_as_mem_model.sv]
// Purpose: serial configuration memory read by the device in the active serial scheme
// Assumes: the device advances one bit on each rise of the memory clock
// Notes:   byte k of the image is BASE + k; deselected, the line shows the inverted last bit
`timescale 1ns/1ns
module cfg_as_mem_model #(
   parameter logic [7:0] BASE = 8'hA0
) (
   input  wire logic i_sclk,
   input  wire logic i_cs_n,
   output logic      o_data
);
   int unsigned bit_cnt;
   logic [7:0]  cur_byte;
   logic        last_bit;
   // the device is the controller: it clocks and selects, the memory only answers
   always @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         bit_cnt <= 0;
      end else begin
         bit_cnt <= bit_cnt + 1;
      end
   end
   assign cur_byte = BASE + 8'(bit_cnt / 8);
   always @(*) begin
      if (!i_cs_n) begin
         last_bit = cur_byte[7 - (bit_cnt % 8)];
      end
   end
   // msb first while selected
   assign o_data = i_cs_n ? ~last_bit : cur_byte[7 - (bit_cnt % 8)];
endmodule

// [sim/tb_fpga_config_mode_sequencer.sv]
// Purpose: self-checking bench of the mode sequencer
// Assumes: 12-byte image and a 2000-cycle load limit
// Notes:   bits enter at rising edges; outputs are sampled at falling edges
`timescale 1ns/1ns
`include "cfg_seq_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_fpga_config_mode_sequencer;
   import cfg_seq_pkg::*;
   logic       clk = 0, srst = 1, reload_n = 1, chain_in_n = 1;
   logic [1:0] scheme = 2'h1;
   logic [3:0] jpos = 4'h1;
   logic       jiv = 0, jbv = 0, jb = 0, psv = 0, psb = 0, as_data, wr_ready = 1;
   logic [9:0] jinstr = 10'h000;
   logic       ser_rdy, sclk, cs_n, wr_valid, stat_n, chain_out_n, cmd, user, urst, pull, drv;
   logic [7:0] wr_data;
   logic [7:0] rx_q[$];
   int         bad_count = 0, total_checks = 0, cyc = 0;

   cfg_mode_sequencer #(.LOAD_TIMEOUT_CYC(2000), .LOAD_BYTES(12)) u_cfg_mode_sequencer (
      .i_clk(clk), .i_srst(srst), .i_reload_request_n(reload_n),
      .i_chain_enable_in_n(chain_in_n), .i_scheme(scheme), .i_jtag_position(jpos),
      .i_jtag_instr_valid(jiv), .i_jtag_instr(jinstr), .i_jtag_bit_valid(jbv),
      .i_jtag_bit(jb), .i_ps_bit_valid(psv), .i_ps_bit(psb), .o_serial_ready(ser_rdy),
      .o_as_sclk(sclk), .o_as_cs_n(cs_n), .i_as_data(as_data), .o_cfg_wr_valid(wr_valid),
      .o_cfg_wr_data(wr_data), .i_cfg_wr_ready(wr_ready), .o_load_status_n(stat_n),
      .o_chain_enable_out_n(chain_out_n), .o_command_mode(cmd), .o_user_mode(user),
      .o_user_reset(urst), .o_io_pullup_en(pull), .o_io_drive_en(drv));
   cfg_as_mem_model #(.BASE(8'hA0)) u_cfg_as_mem_model (
      .i_sclk(sclk), .i_cs_n(cs_n), .o_data(as_data));

   initial begin
      forever #50 clk = ~clk;
   end
   // sink: collect every byte popped
   always @(posedge clk) begin
      if (wr_valid && wr_ready) rx_q.push_back(wr_data);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic close_out();
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cycles(int n);
      repeat (n) @(negedge clk);
   endtask
   // reload pin pulse, a three-cycle wait with chain held off, then start
   task automatic restart(logic [1:0] sch, logic [3:0] pos);
      @(posedge clk);
      reload_n <= 0; chain_in_n <= 1; scheme <= sch; jpos <= pos; rx_q.delete();
      cycles(2);
      `CHK({cmd, user, pull, drv}, 4'hA)
      @(posedge clk);
      reload_n <= 1;
      cycles(3);
      `CHK({ser_rdy, stat_n, cmd}, 3'h3)
      @(posedge clk);
      chain_in_n <= 0;
   endtask
   task automatic send(bit jtag, logic [7:0] base, int first, int n);
      logic [7:0] v;
      for (int k = first; k < first + n; k++) begin
         v = base + 8'(k);
         for (int i = 7; i >= 0; i--) begin
            if (jtag) begin jbv <= 1; jb <= v[i]; end
            else begin psv <= 1; psb <= v[i]; end
            repeat (400) begin
               @(negedge clk);
               if (ser_rdy === 1'b1) break;
            end
            @(posedge clk);
         end
      end
      jbv <= 0; psv <= 0;
   endtask
   task automatic check_rx(logic [7:0] base);
      repeat (400) begin
         @(negedge clk);
         if (rx_q.size() >= 12) break;
      end
      `CHK(rx_q.size(), 12)
      foreach (rx_q[k]) `CHK(rx_q[k], base + 8'(k))
   endtask
   task automatic instr(logic [9:0] code);
      @(posedge clk);
      jiv <= 1; jinstr <= code;
      @(posedge clk);
      jiv <= 0;
      @(negedge clk);
   endtask

   task automatic t_reset();
      `CHK({stat_n, chain_out_n, cmd, user, urst, pull, drv, cs_n}, 8'hED)
   endtask
   task automatic t_ps_fill_and_init();
      restart(SCH_PASSIVE, 4'h1);
      wr_ready <= 0;
      // eight bytes fill the buffer, the ninth stays pending and stalls intake
      send(0, 8'h81, 0, 9);
      cycles(4);
      `CHK({ser_rdy, wr_valid, cmd, pull}, 4'h7)
      @(posedge clk);
      wr_ready <= 1;
      send(0, 8'h81, 9, 3);
      check_rx(8'h81);
      repeat (40) begin
         @(negedge clk);
         if (chain_out_n === 1'b0) break;
      end
      `CHK({chain_out_n, urst, drv, cmd, user}, 5'h0A)
      cycles(7);
      `CHK({urst, drv}, 2'h2)
      cycles(1);
      `CHK({urst, drv, pull, user}, 4'h4)
      cycles(7);
      `CHK({cmd, user}, 2'h2)
      cycles(1);
      `CHK({cmd, user}, 2'h1)
   endtask
   task automatic t_active();
      restart(SCH_ACTIVE, 4'h1);
      cycles(4);
      `CHK(cs_n, 1'b0)
      check_rx(8'hA0);
      cycles(20);
      `CHK({cs_n, user, stat_n}, 3'h7)
   endtask
   task automatic t_jtag();
      restart(SCH_JTAG, 4'h9);
      cycles(3);
      `CHK(stat_n, 1'b0)
      restart(SCH_JTAG, `CFG_JTAG_MAX_POS);
      send(1, 8'h27, 0, 12);
      check_rx(8'h27);
      cycles(20);
      `CHK(user, 1'b1)
      instr(`CFG_INSTR_IO_CFG);
      `CHK({user, stat_n}, 2'h3)
      instr(`CFG_INSTR_RELOAD);
      `CHK({cmd, user}, 2'h2)
   endtask
   task automatic t_faults();
      restart(SCH_PASSIVE, 4'h1);
      send(0, 8'h10, 0, 2);
      instr(`CFG_INSTR_IO_CFG);
      `CHK({stat_n, cmd}, 2'h1)
      cycles(30);
      `CHK(stat_n, 1'b0)
      restart(SCH_PASSIVE, 4'h1);
      cycles(1990);
      `CHK(stat_n, 1'b1)
      cycles(20);
      `CHK(stat_n, 1'b0)
      restart(2'h3, 4'h1);
      cycles(3);
      `CHK(stat_n, 1'b0)
   endtask

   initial begin
      cycles(10);
      @(posedge clk);
      srst <= 0;
      @(negedge clk);
      t_reset();
      t_ps_fill_and_init();
      t_active();
      t_jtag();
      t_faults();
      close_out();
   end
endmodule
